// [core/asr_ctrl.sv]
`timescale 1ns/10ps
`default_nettype none
module asr_ctrl (
    // clock and reset
    input wire logic mclk,
    input wire logic rst,
    // user request
    input wire logic req_valid,
    output logic req_ready,
    input wire logic req_write,
    input wire logic [15:0] req_addr,
    input wire logic [15:0] req_wdata,
    input wire logic [1:0] req_lane_n,
    output logic rsp_valid,
    output logic [15:0] rsp_rdata,
    // memory pins
    output logic mem_cs_n,
    output logic mem_we_n,
    output logic mem_oe_n,
    output logic low_lane_en_n,
    output logic high_lane_en_n,
    output logic [15:0] mem_addr,
    input wire logic [15:0] mem_dq_in,
    output logic [15:0] mem_dq_out,
    output logic mem_dq_oe
);
    //------------------------------------------------------------------
    // state
    //------------------------------------------------------------------
    asr_pkg::asr_state_t state_ff, nxt_state;
    logic [3:0] cnt_ff, nxt_cnt;
    logic [15:0] dq_s1_ff, dq_s2_ff;
    logic wr_ff;

    // pin input passes two flops before use
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            dq_s1_ff <= 16'h0000;
            dq_s2_ff <= 16'h0000;
        end else begin
            dq_s1_ff <= mem_dq_in;
            dq_s2_ff <= dq_s1_ff;
        end
    end

    assign req_ready = (state_ff == asr_pkg::ASR_IDLE);

    always_comb begin
        nxt_state = state_ff;
        nxt_cnt = cnt_ff;
        case (state_ff)
            asr_pkg::ASR_IDLE: begin
                if (req_valid) begin
                    nxt_state = req_write ? asr_pkg::ASR_WR_SEL
                                          : asr_pkg::ASR_RD_SEL;
                end
            end
            // address latched on the same edge that select falls
            asr_pkg::ASR_RD_SEL: begin
                nxt_state = asr_pkg::ASR_RD_WAIT;
                nxt_cnt = 4'(asr_pkg::RD_CYC + 2);
            end
            asr_pkg::ASR_RD_WAIT: begin
                nxt_cnt = cnt_ff - 4'h1;
                if (cnt_ff == 4'h1) begin
                    nxt_state = asr_pkg::ASR_TURN;
                    nxt_cnt = 4'(asr_pkg::HIZ_CYC);
                end
            end
            asr_pkg::ASR_WR_SEL: begin
                nxt_state = asr_pkg::ASR_WR_PULSE;
                nxt_cnt = 4'(asr_pkg::WR_CYC);
            end
            asr_pkg::ASR_WR_PULSE: begin
                nxt_cnt = cnt_ff - 4'h1;
                if (cnt_ff == 4'h1) begin
                    nxt_state = asr_pkg::ASR_WR_END;
                end
            end
            asr_pkg::ASR_WR_END: begin
                nxt_state = asr_pkg::ASR_TURN;
                nxt_cnt = 4'(asr_pkg::HIZ_CYC);
            end
            asr_pkg::ASR_TURN: begin
                nxt_cnt = cnt_ff - 4'h1;
                if (cnt_ff <= 4'h1) begin
                    nxt_state = asr_pkg::ASR_IDLE;
                    nxt_cnt = asr_pkg::CNT_ZERO;
                end
            end
            default: begin
                nxt_state = asr_pkg::ASR_IDLE;
                nxt_cnt = asr_pkg::CNT_ZERO;
            end
        endcase
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            state_ff <= asr_pkg::ASR_IDLE;
            cnt_ff <= 4'h0;
        end else begin
            state_ff <= nxt_state;
            cnt_ff <= nxt_cnt;
        end
    end

    //------------------------------------------------------------------
    // pins
    //------------------------------------------------------------------
    // address and data latched at accept, held through cycle
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            mem_addr <= 16'h0000;
            mem_dq_out <= 16'h0000;
            low_lane_en_n <= 1'b1;
            high_lane_en_n <= 1'b1;
            wr_ff <= 1'b0;
        end else if (state_ff == asr_pkg::ASR_IDLE && req_valid) begin
            mem_addr <= req_addr;
            mem_dq_out <= req_wdata;
            low_lane_en_n <= req_lane_n[0];
            high_lane_en_n <= req_lane_n[1];
            wr_ff <= req_write;
        end else if (nxt_state == asr_pkg::ASR_IDLE) begin
            low_lane_en_n <= 1'b1;
            high_lane_en_n <= 1'b1;
        end
    end

    // select low only during access; high otherwise for standby
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            mem_cs_n <= 1'b1;
            mem_we_n <= 1'b1;
            mem_oe_n <= 1'b1;
            mem_dq_oe <= 1'b0;
        end else begin
            // select stays low past strobe rise: no joint rise
            mem_cs_n <= !(nxt_state == asr_pkg::ASR_RD_SEL ||
                          nxt_state == asr_pkg::ASR_RD_WAIT ||
                          nxt_state == asr_pkg::ASR_WR_SEL ||
                          nxt_state == asr_pkg::ASR_WR_PULSE ||
                          nxt_state == asr_pkg::ASR_WR_END);
            // strobe only inside select; strobe rises first
            mem_we_n <= !(nxt_state == asr_pkg::ASR_WR_PULSE);
            // oe low only on reads with strobe high
            mem_oe_n <= !(nxt_state == asr_pkg::ASR_RD_SEL ||
                          nxt_state == asr_pkg::ASR_RD_WAIT);
            // drive data across the write and one cycle past its end
            mem_dq_oe <= (nxt_state == asr_pkg::ASR_WR_SEL ||
                          nxt_state == asr_pkg::ASR_WR_PULSE ||
                          nxt_state == asr_pkg::ASR_WR_END);
        end
    end

    // capture read data after the synchroniser has settled
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            rsp_valid <= 1'b0;
            rsp_rdata <= 16'h0000;
        end else begin
            rsp_valid <= 1'b0;
            if (state_ff == asr_pkg::ASR_RD_WAIT && cnt_ff == 4'h1) begin
                rsp_valid <= 1'b1;
                rsp_rdata <= dq_s2_ff;
            end
        end
    end

    //------------------------------------------------------------------
    // checks
    //------------------------------------------------------------------
    property p_we_in_cs;
        @(posedge mclk) disable iff (rst) !mem_we_n |-> !mem_cs_n;
    endproperty
    a_we_in_cs: assert property (p_we_in_cs)
        else $error("write strobe outside select");

    property p_we_oe_excl;
        @(posedge mclk) disable iff (rst) !(!mem_we_n && !mem_oe_n);
    endproperty
    a_we_oe_excl: assert property (p_we_oe_excl)
        else $error("strobe and output enable both low");

    property p_no_clash;
        @(posedge mclk) disable iff (rst) mem_dq_oe |-> mem_oe_n;
    endproperty
    a_no_clash: assert property (p_no_clash)
        else $error("driving bus while memory may drive");

    property p_pulse_len;
        @(posedge mclk) disable iff (rst)
            $fell(mem_we_n) |-> !mem_we_n [*3] ##1 mem_we_n;
    endproperty
    a_pulse_len: assert property (p_pulse_len)
        else $error("write pulse length wrong");

    property p_we_first;
        @(posedge mclk) disable iff (rst)
            $rose(mem_we_n) |-> !mem_cs_n && mem_dq_oe;
    endproperty
    a_we_first: assert property (p_we_first)
        else $error("strobe did not end write first");

    property p_addr_hold;
        @(posedge mclk) disable iff (rst)
            !mem_cs_n && !$fell(mem_cs_n) |-> $stable(mem_addr);
    endproperty
    a_addr_hold: assert property (p_addr_hold)
        else $error("address moved during access");

    property p_data_hold;
        @(posedge mclk) disable iff (rst)
            $rose(mem_we_n) |-> mem_dq_oe && $stable(mem_dq_out);
    endproperty
    a_data_hold: assert property (p_data_hold)
        else $error("data released before write end");

    property p_standby;
        @(posedge mclk) disable iff (rst)
            state_ff == asr_pkg::ASR_IDLE |-> mem_cs_n;
    endproperty
    a_standby: assert property (p_standby)
        else $error("select low while idle");

    property p_rd_rsp;
        @(posedge mclk) disable iff (rst)
            $fell(mem_oe_n) |-> ##[1:12] rsp_valid;
    endproperty
    a_rd_rsp: assert property (p_rd_rsp)
        else $error("read response missing");

    c_read: cover property (@(posedge mclk) rsp_valid);
    c_write: cover property (@(posedge mclk) $rose(mem_we_n));
    c_low_only: cover property (@(posedge mclk)
        !mem_we_n && !low_lane_en_n && high_lane_en_n);
endmodule : asr_ctrl
`default_nettype wire

// [core/asr_pkg.sv]
//----------------------------------------------------------------------
// constants
//----------------------------------------------------------------------
package asr_pkg;
    localparam int ADDR_W = 16;
    localparam int DATA_W = 16;
    localparam int LANE_W = 8;
    localparam int CLK_PERIOD_NS = 4;
    // access time and write pulse width of the slower grade
    localparam int T_ACCESS_NS = 15;
    localparam int T_WRPULSE_NS = 10;
    localparam int T_DSETUP_NS = 8;
    localparam int T_HIZ_NS = 7;
    function automatic int cyc_up(input int ns);
        return ((ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS) < 1 ? 1 :
               ((ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    endfunction : cyc_up
    localparam int RD_CYC = cyc_up(T_ACCESS_NS) + 1;
    localparam int WR_CYC = cyc_up(T_WRPULSE_NS);
    localparam int SETUP_CYC = cyc_up(T_DSETUP_NS);
    localparam int HIZ_CYC = cyc_up(T_HIZ_NS);
    localparam logic [3:0] CNT_ZERO = 4'h0;
    typedef enum logic [2:0] {
        ASR_IDLE, ASR_RD_SEL, ASR_RD_WAIT, ASR_WR_SEL,
        ASR_WR_PULSE, ASR_WR_END, ASR_TURN
    } asr_state_t;
endpackage : asr_pkg

// [bench/asr_sram_model.sv]
`timescale 1ns/10ps
`default_nettype none
// ------
// sram model
// ------
module asr_sram_model #(
    parameter int ACC_NS = 15
) (
    // strobes
    input wire logic cs_n,
    input wire logic we_n,
    input wire logic oe_n,
    input wire logic low_lane_en_n,
    input wire logic high_lane_en_n,
    // address and data
    input wire logic [15:0] addr,
    input wire logic [15:0] dq_in,
    output logic [15:0] dq_out,
    output logic [1:0] dq_drv
);
    logic [15:0] mem [0:65535];
    logic standby;
    wire logic rd_act;
    wire logic rd_late;
    assign standby = cs_n;
    // no read while writing or deselected
    assign rd_act = !standby && !oe_n && we_n;
    assign #(ACC_NS) rd_late = rd_act;
    always @(*) begin
        if (!cs_n && !we_n) begin
            if (!low_lane_en_n) mem[addr][7:0] = dq_in[7:0];
            if (!high_lane_en_n) mem[addr][15:8] = dq_in[15:8];
        end
    end
    // junk until access time, so early sampling shows up
    assign dq_out = rd_late ? mem[addr] : ~mem[addr];
    // lanes float unless enabled
    assign dq_drv = {rd_act && !high_lane_en_n, rd_act && !low_lane_en_n};
endmodule : asr_sram_model
`default_nettype wire

// [bench/asr_ctrl_tb_top.sv]
`timescale 1ns/10ps
`default_nettype none
// ------
// bench
// ------
module asr_ctrl_tb_top;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic req_valid = 1'b0;
    logic req_write = 1'b0;
    logic [15:0] req_addr = 16'h0;
    logic [15:0] req_wdata = 16'h0;
    logic [1:0] req_lane_n = 2'h3;
    logic req_ready, rsp_valid, mem_cs_n, mem_we_n, mem_oe_n, mem_dq_oe;
    logic low_lane_en_n, high_lane_en_n, flt = 1'b0, prev_sel = 1'b0;
    logic [15:0] rsp_rdata, mem_addr, mem_dq_out, m_out, bus, prev_addr;
    logic [1:0] m_drv, l;
    logic [15:0] addrs [8];
    logic [15:0] shadow [8];
    logic [15:0] r;
    logic [31:0] seed = 32'ha;
    int n_errors = 0;
    int n_checks = 0;
    int i;
    // take, select, strobe, strobe-end and turnaround edges
    localparam logic [15:0] WR_LAT =
        16'(asr_pkg::WR_CYC + asr_pkg::HIZ_CYC + 2);
    // take, select and access wait including the sync flops
    localparam logic [15:0] RD_LAT = 16'(asr_pkg::RD_CYC + 3);
    always #2 mclk = ~mclk;
    always @(posedge mclk) flt <= ~flt;
    // released lanes toggle so a stale value is never read back
    assign bus[7:0] = mem_dq_oe ? mem_dq_out[7:0] :
                      m_drv[0] ? m_out[7:0] : {8{flt}};
    assign bus[15:8] = mem_dq_oe ? mem_dq_out[15:8] :
                       m_drv[1] ? m_out[15:8] : {8{flt}};
    asr_ctrl u_asr_ctrl (.mclk(mclk), .rst(rst), .req_valid(req_valid),
        .req_ready(req_ready), .req_write(req_write), .req_addr(req_addr),
        .req_wdata(req_wdata), .req_lane_n(req_lane_n),
        .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .mem_cs_n(mem_cs_n),
        .mem_we_n(mem_we_n), .mem_oe_n(mem_oe_n),
        .low_lane_en_n(low_lane_en_n), .high_lane_en_n(high_lane_en_n),
        .mem_addr(mem_addr), .mem_dq_in(bus), .mem_dq_out(mem_dq_out),
        .mem_dq_oe(mem_dq_oe));
    asr_sram_model u_asr_sram_model (.cs_n(mem_cs_n), .we_n(mem_we_n),
        .oe_n(mem_oe_n), .low_lane_en_n(low_lane_en_n),
        .high_lane_en_n(high_lane_en_n), .addr(mem_addr), .dq_in(bus),
        .dq_out(m_out), .dq_drv(m_drv));
    function automatic logic [15:0] rnd16();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[15:0];
    endfunction : rnd16
    function automatic logic [15:0] lmask(input logic [1:0] m);
        return {{8{~m[1]}}, {8{~m[0]}}};
    endfunction : lmask
    function automatic logic [15:0] merge(input logic [15:0] o, n,
                                          input logic [1:0] m);
        return (o & ~lmask(m)) | (n & lmask(m));
    endfunction : merge
    task automatic check(input string what, input logic [15:0] seen, exp);
        n_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic close_out;
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : close_out
    task automatic xfer(input logic w, input logic [15:0] a, d,
                        input logic [1:0] m);
        int n;
        n = 0;
        while (req_ready !== 1'b1) begin
            @(posedge mclk);
            #1;
        end
        req_valid = 1'b1;
        req_write = w;
        req_addr = a;
        req_wdata = d;
        req_lane_n = m;
        @(posedge mclk);
        #1;
        req_valid = 1'b0;
        req_wdata = rnd16();
        do begin
            @(posedge mclk);
            #1;
            n++;
        end while ((w ? req_ready : rsp_valid) !== 1'b1 && n < 20);
        check("latency", 16'(n), w ? WR_LAT : RD_LAT);
    endtask : xfer
    task automatic rd(input int k, input logic [1:0] m);
        xfer(1'b0, addrs[k], rnd16(), m);
        check("rdata", rsp_rdata & lmask(m), shadow[k] & lmask(m));
    endtask : rd
    always @(posedge mclk) begin
        if (!rst && !mem_cs_n) begin
            if (prev_sel) check("addr hold", mem_addr, prev_addr);
            if (!mem_we_n) check("wr pins", 16'({mem_oe_n, mem_dq_oe}), 16'h3);
            if (!mem_oe_n) check("rd pins", 16'({mem_we_n, mem_dq_oe}), 16'h2);
        end
        prev_sel <= !rst && !mem_cs_n;
        prev_addr <= mem_addr;
    end
    initial begin
        #100000;
        n_errors++;
        close_out;
    end
    initial begin
        repeat (10) @(posedge mclk);
        #1;
        rst = 1'b0;
        for (int k = 0; k < 8; k++) begin
            addrs[k] = k == 0 ? 16'h0 : (k == 7 ? 16'hffff : rnd16());
            shadow[k] = rnd16();
            xfer(1'b1, addrs[k], shadow[k], 2'h0);
        end
        for (int k = 0; k < 8; k++) rd(k, 2'h0);
        $display("test fill done");
        // first writes sweep every lane code, incl. none enabled
        for (int k = 0; k < 40; k++) begin
            r = rnd16();
            i = int'(r & 16'h7);
            l = k < 4 ? 2'(k) : r[5:4];
            r = rnd16();
            xfer(1'b1, addrs[i], r, l);
            shadow[i] = merge(shadow[i], r, l);
            r = rnd16();
            rd(i, k < 4 ? 2'h0 : (k < 8 ? 2'(k) : r[1:0]));
        end
        $display("test lanes done");
        xfer(1'b0, addrs[1], 16'h0, 2'h0);
        // wait for idle so the reset really cuts a read in flight
        while (req_ready !== 1'b1) begin
            @(posedge mclk);
            #1;
        end
        req_valid = 1'b1;
        @(posedge mclk);
        #1;
        req_valid = 1'b0;
        repeat (3) @(posedge mclk);
        #1;
        rst = 1'b1;
        #1;
        check("reset pins", 16'({mem_cs_n, mem_we_n, mem_oe_n, low_lane_en_n,
              high_lane_en_n, mem_dq_oe, req_ready}), 16'h7d);
        @(posedge mclk);
        #1;
        rst = 1'b0;
        rd(1, 2'h0);
        $display("test reset done");
        close_out;
    end
endmodule : asr_ctrl_tb_top
`default_nettype wire
